// ### tm2_regs.vh
`ifndef TM2_REGS_VH
`define TM2_REGS_VH

// Register indices; byte address is four times the index
`define TM2_IDX_CLKDIV 8'h8e
`define TM2_IDX_IRQ_EN 8'ha8
`define TM2_IDX_IRQ_PRIO 8'hb8
`define TM2_IDX_MODE 8'hc8
`define TM2_IDX_RLD_LO 8'hca
`define TM2_IDX_RLD_HI 8'hcb
`define TM2_IDX_CNT_LO 8'hcc
`define TM2_IDX_CNT_HI 8'hcd
`define TM2_IDX_EVT_STATUS 8'hd0
`define TM2_IDX_EVT_MASK 8'hd1

// Field positions
`define TM2_BIT_PRESCALE 5
`define TM2_BIT_GLOBAL_EN 7
`define TM2_BIT_TIMER_EN 5
`define TM2_BIT_TIMER_PRIO 5
`define TM2_BIT_OVF_FLAG 7
`define TM2_BIT_EDGE_FLAG 6
`define TM2_BIT_RX_BAUD 5
`define TM2_BIT_TX_BAUD 4
`define TM2_BIT_PIN_EN 3
`define TM2_BIT_RUN 2
`define TM2_BIT_SRC_SEL 1
`define TM2_BIT_CAP_SEL 0
`define TM2_EVT_OVF 0
`define TM2_EVT_EDGE 1

// Reset values
`define TM2_RST_BYTE 8'h00
`define TM2_RST_EVT 2'h0

// Prescale counts in system clocks
`define TM2_DIV_TIMER_SLOW 4'hc
`define TM2_DIV_TIMER_FAST 4'h4
`define TM2_DIV_BAUD 4'h2

`endif

// ### tm2_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "tm2_regs.vh"

module tm2_timer (
    // Clock and reset
    input wire clock_in,
    input wire resetn_in,
    // Avalon-MM slave
    input wire [9:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // Pins
    input wire ext_count_pin_in,
    input wire ext_control_pin_in,
    // Serial port side
    input wire timer1_overflow_in,
    output reg rx_baud_tick_out,
    output reg tx_baud_tick_out,
    // Interrupts
    output wire timer_irq_req_out,
    output wire timer_irq_high_out,
    output wire irq_out
);

    reg [7:0] clkdiv_ctl;
    reg [7:0] irq_en;
    reg [7:0] irq_prio;
    reg [7:0] mode_ctl;
    reg [7:0] rld_lo;
    reg [7:0] rld_hi;
    reg [7:0] cnt_lo;
    reg [7:0] cnt_hi;
    reg [1:0] evt_status;
    reg [1:0] evt_mask;
    reg bus_ack;
    reg [3:0] pre_cnt;
    reg [7:0] next_mode;
    reg [15:0] next_count;
    reg [15:0] next_reload;
    reg [7:0] rd_mux;

    // Synchroniser stages; stage three only feeds the edge detectors
    wire [1:0] pin_raw;
    wire [1:0] pin_fall;

    wire [15:0] count;
    wire [15:0] reload_value;
    wire rx_sel;
    wire tx_sel;
    wire baud_mode;
    wire run;
    wire pin_en;
    wire src_sel;
    wire cap_sel;
    wire [3:0] pre_top;
    wire pre_tick;
    wire count_tick;
    wire overflow;
    wire ctl_edge;
    wire ovf_set;
    wire edge_set;
    wire do_reload;
    wire do_capture;
    wire bus_req;
    wire bus_wr;
    wire [7:0] wdata;
    // One address decode per register, shared by reads and writes
    wire sel_clkdiv;
    wire sel_irq_en;
    wire sel_irq_prio;
    wire sel_mode;
    wire sel_rld_lo;
    wire sel_rld_hi;
    wire sel_cnt_lo;
    wire sel_cnt_hi;
    wire sel_evt_status;
    wire sel_evt_mask;
    wire wr_clkdiv;
    wire wr_irq_en;
    wire wr_irq_prio;
    wire wr_mode;
    wire wr_rld_lo;
    wire wr_rld_hi;
    wire wr_cnt_lo;
    wire wr_cnt_hi;
    wire wr_evt_status;
    wire wr_evt_mask;
    wire [1:0] evt_set;
    wire [1:0] evt_clr;

    function reg_hit;
        input [9:0] addr;
        input [7:0] idx;
        begin
            reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
        end
    endfunction

    assign count = {cnt_hi, cnt_lo};
    assign reload_value = {rld_hi, rld_lo};
    assign rx_sel = mode_ctl[`TM2_BIT_RX_BAUD];
    assign tx_sel = mode_ctl[`TM2_BIT_TX_BAUD];
    assign baud_mode = rx_sel | tx_sel;
    assign run = mode_ctl[`TM2_BIT_RUN];
    assign pin_en = mode_ctl[`TM2_BIT_PIN_EN];
    assign src_sel = mode_ctl[`TM2_BIT_SRC_SEL];
    assign cap_sel = mode_ctl[`TM2_BIT_CAP_SEL];

    assign pin_raw = {ext_control_pin_in, ext_count_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            reg s1;
            reg s2;
            reg s3;
            // Reset high so release with the pin high never looks like a falling edge
            always @(posedge clock_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                end else begin
                    s1 <= pin_raw[gi];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign pin_fall[gi] = s3 & ~s2;
        end
    endgenerate

    // Baud mode runs at clock/2, giving clock/(2*(65536-reload)) per tick
    assign pre_top = baud_mode ? (`TM2_DIV_BAUD - 4'h1) :
        clkdiv_ctl[`TM2_BIT_PRESCALE] ? (`TM2_DIV_TIMER_FAST - 4'h1) :
        (`TM2_DIV_TIMER_SLOW - 4'h1);
    // Compare with >= so a mode change never strands the prescaler
    assign pre_tick = (pre_cnt >= pre_top);

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pre_cnt <= 4'h0;
        end else if (!run || pre_tick) begin
            pre_cnt <= 4'h0;
        end else begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    assign count_tick = run & (src_sel ? pin_fall[0] : pre_tick);
    assign overflow = count_tick & (count == 16'hffff);
    assign ctl_edge = pin_en & pin_fall[1];
    assign ovf_set = overflow & ~baud_mode;
    assign edge_set = ctl_edge;
    assign do_reload = overflow & (baud_mode | ~cap_sel)
        | run & ctl_edge & ~baud_mode & ~cap_sel;
    assign do_capture = run & ctl_edge & ~baud_mode & cap_sel;

    // Bus: one wait cycle on every access, answer in the second
    assign bus_req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~bus_ack;
    assign bus_wr = avs_write_in & bus_ack & avs_byteenable_in[0];
    assign wdata = avs_writedata_in[7:0];

    // Address decode, shared by the read mux and the write strobes
    assign sel_clkdiv = reg_hit(avs_address_in, `TM2_IDX_CLKDIV);
    assign sel_irq_en = reg_hit(avs_address_in, `TM2_IDX_IRQ_EN);
    assign sel_irq_prio = reg_hit(avs_address_in, `TM2_IDX_IRQ_PRIO);
    assign sel_mode = reg_hit(avs_address_in, `TM2_IDX_MODE);
    assign sel_rld_lo = reg_hit(avs_address_in, `TM2_IDX_RLD_LO);
    assign sel_rld_hi = reg_hit(avs_address_in, `TM2_IDX_RLD_HI);
    assign sel_cnt_lo = reg_hit(avs_address_in, `TM2_IDX_CNT_LO);
    assign sel_cnt_hi = reg_hit(avs_address_in, `TM2_IDX_CNT_HI);
    assign sel_evt_status = reg_hit(avs_address_in, `TM2_IDX_EVT_STATUS);
    assign sel_evt_mask = reg_hit(avs_address_in, `TM2_IDX_EVT_MASK);

    // Strobes fire only at the answering edge
    assign wr_clkdiv = bus_wr & sel_clkdiv;
    assign wr_irq_en = bus_wr & sel_irq_en;
    assign wr_irq_prio = bus_wr & sel_irq_prio;
    assign wr_mode = bus_wr & sel_mode;
    assign wr_rld_lo = bus_wr & sel_rld_lo;
    assign wr_rld_hi = bus_wr & sel_rld_hi;
    assign wr_cnt_lo = bus_wr & sel_cnt_lo;
    assign wr_cnt_hi = bus_wr & sel_cnt_hi;
    assign wr_evt_status = bus_wr & sel_evt_status;
    assign wr_evt_mask = bus_wr & sel_evt_mask;

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    always @* begin
        rd_mux = 8'h00;
        if (sel_clkdiv) begin
            rd_mux = clkdiv_ctl;
        end else if (sel_irq_en) begin
            rd_mux = irq_en;
        end else if (sel_irq_prio) begin
            rd_mux = irq_prio;
        end else if (sel_mode) begin
            rd_mux = mode_ctl;
        end else if (sel_rld_lo) begin
            rd_mux = rld_lo;
        end else if (sel_rld_hi) begin
            rd_mux = rld_hi;
        end else if (sel_cnt_lo) begin
            rd_mux = cnt_lo;
        end else if (sel_cnt_hi) begin
            rd_mux = cnt_hi;
        end else if (sel_evt_status) begin
            rd_mux = {6'h00, evt_status};
        end else if (sel_evt_mask) begin
            rd_mux = {6'h00, evt_mask};
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in & ~bus_ack) begin
            avs_readdata_out <= {24'h000000, rd_mux};
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always @* begin
        next_mode = mode_ctl;
        if (wr_mode) begin
            next_mode = wdata;
        end
        if (ovf_set) begin
            next_mode[`TM2_BIT_OVF_FLAG] = 1'b1;
        end
        if (edge_set) begin
            next_mode[`TM2_BIT_EDGE_FLAG] = 1'b1;
        end
    end

    // Byte writes from software take precedence over counting
    always @* begin
        next_count = count;
        if (do_reload) begin
            next_count = reload_value;
        end else if (count_tick) begin
            next_count = count + 16'h0001;
        end
        if (wr_cnt_lo) begin
            next_count[7:0] = wdata;
        end
        if (wr_cnt_hi) begin
            next_count[15:8] = wdata;
        end
    end

    // A capture in the same cycle outranks a software write
    always @* begin
        next_reload = reload_value;
        if (wr_rld_lo) begin
            next_reload[7:0] = wdata;
        end
        if (wr_rld_hi) begin
            next_reload[15:8] = wdata;
        end
        if (do_capture) begin
            next_reload = count;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_ctl <= `TM2_RST_BYTE;
        end else begin
            mode_ctl <= next_mode;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {cnt_hi, cnt_lo} <= {`TM2_RST_BYTE, `TM2_RST_BYTE};
        end else begin
            {cnt_hi, cnt_lo} <= next_count;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {rld_hi, rld_lo} <= {`TM2_RST_BYTE, `TM2_RST_BYTE};
        end else begin
            {rld_hi, rld_lo} <= next_reload;
        end
    end

    // Plain control registers, each moved only by its own strobe
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clkdiv_ctl <= `TM2_RST_BYTE;
        end else if (wr_clkdiv) begin
            clkdiv_ctl <= wdata;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_en <= `TM2_RST_BYTE;
        end else if (wr_irq_en) begin
            irq_en <= wdata;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_prio <= `TM2_RST_BYTE;
        end else if (wr_irq_prio) begin
            irq_prio <= wdata;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            evt_mask <= `TM2_RST_EVT;
        end else if (wr_evt_mask) begin
            evt_mask <= wdata[1:0];
        end
    end

    // Sticky event bits, write one to clear; a new event beats the clear
    assign evt_set[`TM2_EVT_OVF] = ovf_set;
    assign evt_set[`TM2_EVT_EDGE] = edge_set;
    assign evt_clr[`TM2_EVT_OVF] = wr_evt_status & wdata[`TM2_EVT_OVF];
    assign evt_clr[`TM2_EVT_EDGE] = wr_evt_status & wdata[`TM2_EVT_EDGE];
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            evt_status <= `TM2_RST_EVT;
        end else begin
            evt_status <= evt_set | (evt_status & ~evt_clr);
        end
    end

    // Doubling belongs to the Timer 1 path outside; our ticks pass unscaled
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_baud_tick_out <= 1'b0;
        end else begin
            rx_baud_tick_out <= rx_sel ? (overflow & baud_mode) :
                timer1_overflow_in;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_baud_tick_out <= 1'b0;
        end else begin
            tx_baud_tick_out <= tx_sel ? (overflow & baud_mode) :
                timer1_overflow_in;
        end
    end

    // Flags read straight from the register, so software writes act alike
    assign timer_irq_req_out = (mode_ctl[`TM2_BIT_OVF_FLAG] | mode_ctl[`TM2_BIT_EDGE_FLAG])
        & irq_en[`TM2_BIT_TIMER_EN] & irq_en[`TM2_BIT_GLOBAL_EN];
    assign timer_irq_high_out = irq_prio[`TM2_BIT_TIMER_PRIO];
    assign irq_out = |(evt_status & evt_mask);

endmodule // tm2_timer

`default_nettype wire

// ### tm2_timer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "tm2_regs.vh"
module tm2_timer_chk (
    // Clock, reset and register bus
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Interrupt outputs
    input wire logic timer_irq_req_out,
    input wire logic timer_irq_high_out,
    input wire logic irq_out
);
    wire req = avs_read_in | avs_write_in;
    wire take = req & ~avs_waitrequest_out;
    // Only a taken lane-0 write may move a register
    wire wtake = take & avs_write_in & avs_byteenable_in[0];
    wire [9:0] en_addr = {`TM2_IDX_IRQ_EN, 2'b00};
    wire [9:0] pr_addr = {`TM2_IDX_IRQ_PRIO, 2'b00};
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
        else $error("request answered with no wait state");
    a_wait_bound: assert property (req |-> ##[0:1] !avs_waitrequest_out)
        else $error("request not answered in time");
    a_unmapped_zero: assert property (take && avs_read_in && avs_address_in[9:8] == 2'b00
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    a_prio_follows: assert property (wtake && avs_address_in == pr_addr
        |=> timer_irq_high_out == $past(avs_writedata_in[5])) else $error("priority wrong");
    a_prio_static: assert property (!$stable(timer_irq_high_out) |-> $past(wtake))
        else $error("priority moved without a write");
    a_enable_gates: assert property (wtake && avs_address_in == en_addr
        && !(avs_writedata_in[7] && avs_writedata_in[5]) |=> !timer_irq_req_out)
        else $error("request stays with an enable clear");
    a_req_sticky: assert property ($fell(timer_irq_req_out) |-> $past(wtake))
        else $error("timer request dropped by itself");
    a_irq_sticky: assert property ($fell(irq_out) |-> $past(wtake))
        else $error("event interrupt dropped by itself");
endmodule // tm2_timer_chk
bind tm2_timer tm2_timer_chk tm2_timer_chk_i (.clock_in(clock_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .timer_irq_req_out(timer_irq_req_out), .timer_irq_high_out(timer_irq_high_out),
    .irq_out(irq_out));
`default_nettype wire

// ### tm2_uart_model.sv
`timescale 1ns/100ps
`default_nettype none
module tm2_uart_model (
    // Clock and Timer 1 enable
    input wire logic clock_in,
    input wire logic t1_run_in,
    // Ticks from the timer
    input wire logic rx_baud_tick_in,
    input wire logic tx_baud_tick_in,
    // Timer 1 pulse and tick counts
    output logic timer1_overflow_out,
    output int rx_ticks_out,
    output int tx_ticks_out
);
    int div = 0;
    initial begin
        timer1_overflow_out = 1'b0;
        rx_ticks_out = 0;
        tx_ticks_out = 0;
    end
    always @(posedge clock_in) begin
        div <= (div == 6) ? 0 : div + 1;
        timer1_overflow_out <= t1_run_in && div == 6;
        rx_ticks_out <= rx_ticks_out + rx_baud_tick_in;
        tx_ticks_out <= tx_ticks_out + tx_baud_tick_in;
    end
endmodule // tm2_uart_model
`default_nettype wire

// ### tm2_timer_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "tm2_regs.vh"
module tm2_timer_test;
    localparam logic [7:0] ckd = `TM2_IDX_CLKDIV, ien = `TM2_IDX_IRQ_EN, ipr = `TM2_IDX_IRQ_PRIO;
    localparam logic [7:0] mde = `TM2_IDX_MODE, rlo = `TM2_IDX_RLD_LO, rhi = `TM2_IDX_RLD_HI;
    localparam logic [7:0] clo = `TM2_IDX_CNT_LO, chi = `TM2_IDX_CNT_HI;
    localparam logic [7:0] sts = `TM2_IDX_EVT_STATUS, msk = `TM2_IDX_EVT_MASK;
    logic clk, rstn, rd, wr, cnt_pin, ctl_pin, t1_run;
    logic [3:0] be;
    logic [9:0] addr;
    logic [31:0] wd, lfsr;
    logic [7:0] q;
    logic [7:0] ids [10];
    wire [31:0] rdat;
    wire wq, t1o, rxt, txt, ireq, ihigh, irq;
    int failures, n_compared, rxn, txn, n0, m0;
    int regm [logic [7:0]];
    tm2_timer tm2_timer_i (.clock_in(clk), .resetn_in(rstn), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .ext_count_pin_in(cnt_pin),
        .ext_control_pin_in(ctl_pin), .timer1_overflow_in(t1o), .rx_baud_tick_out(rxt),
        .tx_baud_tick_out(txt), .timer_irq_req_out(ireq), .timer_irq_high_out(ihigh),
        .irq_out(irq));
    tm2_uart_model tm2_uart_model_i (.clock_in(clk), .t1_run_in(t1_run),
        .rx_baud_tick_in(rxt), .tx_baud_tick_in(txt), .timer1_overflow_out(t1o),
        .rx_ticks_out(rxn), .tx_ticks_out(txn));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
        n_compared++;
        if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= {idx, 2'b00};
        wd <= {24'h0, d};
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
        regm[idx] = d;
    endtask
    task automatic wregs(input logic [7:0] l [$]);
        for (int i = 0; i < l.size(); i += 2)
            wreg(l[i], l[i + 1]);
    endtask
    task automatic rchk(input logic [7:0] idx);
        bus(1'b0, idx, 8'h00);
        chk(q, regm.exists(idx) ? regm[idx] : 0);
    endtask
    // Fall held four clocks so the synchroniser sees it
    task automatic pulse(input logic cnt);
        if (cnt) cnt_pin <= 1'b0;
        else ctl_pin <= 1'b0;
        repeat (4) @(posedge clk);
        cnt_pin <= 1'b1;
        ctl_pin <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test;
    end
    initial begin
        {rstn, rd, wr, t1_run} = 4'h0;
        {cnt_pin, ctl_pin} = 2'b11;
        be = 4'h1;
        addr = 10'h0;
        wd = 32'h0;
        lfsr = 32'hfb8baf7f;
        ids = '{ckd, ien, ipr, mde, rlo, rhi, clo, chi, sts, msk};
        foreach (ids[i]) regm[ids[i]] = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        foreach (ids[i]) rchk(ids[i]);
        bus(1'b1, 8'h10, 8'h5a);
        rchk(8'h10);
        $display("test reset values done");
        foreach (ids[i]) if (ids[i] != mde && ids[i] < sts) begin
            lfsr = nxt(lfsr);
            wreg(ids[i], lfsr[7:0]);
        end
        foreach (ids[i]) rchk(ids[i]);
        chk(ihigh, regm[ipr][5]);
        be <= 4'h0;
        bus(1'b1, rlo, 8'h77);
        be <= 4'h1;
        rchk(rlo);
        $display("test register access done");
        for (int p = 0; p < 2; p++) begin
            wregs('{ckd, p ? 8'h20 : 8'h00, clo, 8'h00, chi, 8'h00, mde, 8'h04});
            repeat (240) @(posedge clk);
            wreg(mde, 8'h00);
            bus(1'b0, clo, 8'h00);
            chk(q, 243 / (p ? 4 : 12), 1);
            m0 = q;
            repeat (30) @(posedge clk);
            bus(1'b0, clo, 8'h00);
            chk(q, m0);
        end
        $display("test prescale done");
        wregs('{ckd, 8'h20, rlo, 8'hf0, rhi, 8'hff, clo, 8'hfe, chi, 8'hff, msk, 8'h01});
        wregs('{ien, 8'ha0, mde, 8'h04});
        repeat (20) @(posedge clk);
        bus(1'b0, mde, 8'h00);
        chk(q, 8'h84);
        wreg(mde, 8'h80);
        bus(1'b0, chi, 8'h00);
        chk(q, 8'hff);
        bus(1'b0, clo, 8'h00);
        chk(q, 8'hf4, 1);
        chk(ireq, 1'b1);
        chk(irq, 1'b1);
        bus(1'b0, sts, 8'h00);
        chk(q, 8'h01);
        wreg(ien, 8'h20);
        @(posedge clk);
        chk(ireq, 1'b0);
        wregs('{ien, 8'ha0, mde, 8'h00});
        @(posedge clk);
        chk(ireq, 1'b0);
        wreg(mde, 8'h40);
        @(posedge clk);
        chk(ireq, 1'b1);
        wreg(msk, 8'h00);
        @(posedge clk);
        chk(irq, 1'b0);
        bus(1'b1, sts, 8'h01);
        rchk(sts);
        $display("test reload and interrupts done");
        wregs('{mde, 8'h00, rlo, 8'haa, rhi, 8'haa, clo, 8'h00, chi, 8'h00, mde, 8'h0d});
        pulse(1'b0);
        bus(1'b0, mde, 8'h00);
        chk(q, 8'h4d);
        wreg(mde, 8'h00);
        bus(1'b0, rhi, 8'h00);
        chk(q, 8'h00);
        wreg(mde, 8'h04);
        pulse(1'b0);
        rchk(mde);
        wregs('{rlo, 8'h34, rhi, 8'h12, clo, 8'h00, chi, 8'h00, mde, 8'h0c});
        pulse(1'b0);
        wreg(mde, 8'h08);
        bus(1'b0, chi, 8'h00);
        chk(q, 8'h12);
        wregs('{clo, 8'h00, mde, 8'h06});
        repeat (5) pulse(1'b1);
        wreg(mde, 8'h02);
        repeat (3) pulse(1'b1);
        bus(1'b0, clo, 8'h00);
        chk(q, 8'h05);
        $display("test capture and pins done");
        wregs('{rlo, 8'hfc, rhi, 8'hff, clo, 8'hfc, chi, 8'hff, ckd, 8'h00, mde, 8'h34});
        repeat (8) @(posedge clk);
        n0 = rxn;
        m0 = txn;
        repeat (160) @(posedge clk);
        chk(rxn - n0, 20, 1);
        chk(txn - m0, 20, 1);
        rchk(mde);
        t1_run <= 1'b1;
        wreg(mde, 8'h24);
        n0 = rxn;
        m0 = txn;
        repeat (140) @(posedge clk);
        chk(rxn - n0, 17, 1);
        chk(txn - m0, 20, 1);
        wreg(mde, 8'h00);
        $display("test baud generator done");
        finish_test;
    end
endmodule // tm2_timer_test
`default_nettype wire
